// file: hcb_map.vh
// Register offsets, field positions, reset values and timing counts of the hub config slice
`ifndef HCB_MAP_VH
`define HCB_MAP_VH

`define HCB_ADDR_CFG2 8'h07
`define HCB_ADDR_CFG3 8'h08
`define HCB_ADDR_MASK 8'h09

`define HCB_CFG2_DYNAMIC 7
`define HCB_CFG2_OC_HI 5
`define HCB_CFG2_OC_LO 4
`define HCB_CFG2_COMPOUND 3
`define HCB_CFG2_WMASK 8'hB8

`define HCB_CFG3_RENUM 3
`define HCB_CFG3_IND_HI 2
`define HCB_CFG3_IND_LO 1
`define HCB_CFG3_STRING 0
`define HCB_CFG3_WMASK 8'h0F

`define HCB_MASK_WMASK 8'hFE

`define HCB_CFG2_RESET 8'h00
`define HCB_CFG3_RESET 8'h00
`define HCB_MASK_RESET 8'h00

`define HCB_IND_SPEED 2'h1

`define HCB_CLK_KHZ 20000
`define HCB_OC_T0_US 100
`define HCB_OC_T1_US 4000
`define HCB_OC_T2_US 8000
`define HCB_OC_T3_US 16000
`define HCB_DETACH_US 100
`define HCB_US_TO_CYC(us) (((us) * `HCB_CLK_KHZ) / 1000)

`endif

// file: hcb_config_bytes.v
// Hub configuration bytes 2, 3 and fixed-port mask with power switching and over-current filter
`timescale 1ns/1ps
`default_nettype none
`include "hcb_map.vh"

module hcb_config_bytes #(
  parameter [18:0] OC_CYC0 = `HCB_US_TO_CYC(`HCB_OC_T0_US),
  parameter [18:0] OC_CYC1 = `HCB_US_TO_CYC(`HCB_OC_T1_US),
  parameter [18:0] OC_CYC2 = `HCB_US_TO_CYC(`HCB_OC_T2_US),
  parameter [18:0] OC_CYC3 = `HCB_US_TO_CYC(`HCB_OC_T3_US),
  parameter [15:0] DETACH_CYC = `HCB_US_TO_CYC(`HCB_DETACH_US)
) (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_cfg_wr,
  input wire i_cfg_rd,
  input wire [7:0] i_cfg_addr,
  input wire [7:0] i_cfg_wdata,
  output reg [7:0] o_cfg_rdata,
  input wire i_strap_config,
  input wire [1:0] i_fixed_port_straps,
  input wire i_local_supply_sense,
  input wire i_overcurrent_n,
  output wire o_self_powered,
  output wire o_upstream_attach,
  output wire o_port_power_en,
  output wire o_downstream_disconnect,
  output reg o_overcurrent,
  output wire o_compound,
  output wire [7:1] o_fixed_port_mask,
  output wire o_port_renumber_en,
  output wire o_indicator_speed_mode,
  output wire o_indicator_support,
  output wire o_string_en
);

  //--------------------------------------------------------------
  // Local state
  //--------------------------------------------------------------
  localparam [1:0] ST_INIT = 2'h0;
  localparam [1:0] ST_RUN = 2'h1;
  localparam [1:0] ST_DETACH = 2'h2;
  localparam [1:0] SETTLE_LAST = 2'h3;
  localparam [15:0] DETACH_ONE = 16'h0001;
  localparam [18:0] OC_ONE = 19'h00001;

  // Register bank
  reg [7:0] cfg2_q;
  reg [7:0] cfg2_d;
  reg [7:0] cfg3_q;
  reg [7:0] cfg3_d;
  reg [7:0] mask_q;
  reg [7:0] mask_d;
  reg [7:0] rdata_d;

  // Synchronised pins
  reg sense_m_q;
  reg sense_q;
  reg oc_m_q;
  reg oc_q;
  reg strap_cfg_m_q;
  reg strap_cfg_q;
  reg [1:0] straps_m_q;
  reg [1:0] straps_q;

  // Power source state
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [1:0] settle_q;
  reg [1:0] settle_d;
  reg self_q;
  reg self_d;
  reg [15:0] detach_cnt_q;
  reg [15:0] detach_cnt_d;

  // Over-current filter
  reg [18:0] oc_cnt_q;
  reg [18:0] oc_cnt_d;
  reg oc_flag_d;
  reg oc_expired;

  // Reported configuration
  reg [7:1] strap_mask;
  wire wr_cfg2;
  wire wr_cfg3;
  wire wr_mask;
  wire supply_changed;
  wire dynamic_en;
  wire [1:0] oc_code;
  wire [1:0] ind_code;

  //--------------------------------------------------------------
  // Helper functions
  //--------------------------------------------------------------
  // Address match for one strobe
  function addr_hit;
    input strobe;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = strobe && (addr == target);
    end
  endfunction

  // Over-current delay in clock cycles per code
  function [18:0] oc_limit;
    input [1:0] code;
    begin
      case (code)
        2'h0: oc_limit = OC_CYC0;
        2'h1: oc_limit = OC_CYC1;
        2'h2: oc_limit = OC_CYC2;
        default: oc_limit = OC_CYC3;
      endcase
    end
  endfunction

  // Fixed ports named by the strap pair
  function [7:1] strap_decode;
    input [1:0] code;
    begin
      case (code)
        2'h0: strap_decode = 7'h00;
        2'h1: strap_decode = 7'h01;
        2'h2: strap_decode = 7'h03;
        default: strap_decode = 7'h07;
      endcase
    end
  endfunction

  //--------------------------------------------------------------
  // Register writes
  //--------------------------------------------------------------
  assign wr_cfg2 = addr_hit(i_cfg_wr, i_cfg_addr, `HCB_ADDR_CFG2);
  assign wr_cfg3 = addr_hit(i_cfg_wr, i_cfg_addr, `HCB_ADDR_CFG3);
  assign wr_mask = addr_hit(i_cfg_wr, i_cfg_addr, `HCB_ADDR_MASK);

  // Next register values, reserved bits forced low
  always @* begin
    cfg2_d = cfg2_q;
    cfg3_d = cfg3_q;
    mask_d = mask_q;
    if (wr_cfg2) begin
      cfg2_d = i_cfg_wdata & `HCB_CFG2_WMASK;
    end
    if (wr_cfg3) begin
      cfg3_d = i_cfg_wdata & `HCB_CFG3_WMASK;
    end
    if (wr_mask) begin
      mask_d = i_cfg_wdata & `HCB_MASK_WMASK;
    end
  end

  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      cfg2_q <= `HCB_CFG2_RESET;
      cfg3_q <= `HCB_CFG3_RESET;
      mask_q <= `HCB_MASK_RESET;
    end else begin
      cfg2_q <= cfg2_d;
      cfg3_q <= cfg3_d;
      mask_q <= mask_d;
    end
  end

  //--------------------------------------------------------------
  // Register reads
  //--------------------------------------------------------------
  // Read data holds between reads; unmapped addresses return zero
  always @* begin
    rdata_d = o_cfg_rdata;
    if (i_cfg_rd) begin
      case (i_cfg_addr)
        `HCB_ADDR_CFG2: rdata_d = cfg2_q;
        `HCB_ADDR_CFG3: rdata_d = cfg3_q;
        `HCB_ADDR_MASK: rdata_d = mask_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_cfg_rdata <= 8'h00;
    end else begin
      o_cfg_rdata <= rdata_d;
    end
  end

  //--------------------------------------------------------------
  // Pin synchronisers
  //--------------------------------------------------------------
  // Power sense and over-current pins
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      sense_m_q <= 1'b0;
      sense_q <= 1'b0;
      oc_m_q <= 1'b0;
      oc_q <= 1'b0;
    end else begin
      sense_m_q <= i_local_supply_sense;
      sense_q <= sense_m_q;
      oc_m_q <= ~i_overcurrent_n;
      oc_q <= oc_m_q;
    end
  end

  // Strap pins, static in use but still crossing in from outside
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      strap_cfg_m_q <= 1'b0;
      strap_cfg_q <= 1'b0;
      straps_m_q <= 2'h0;
      straps_q <= 2'h0;
    end else begin
      strap_cfg_m_q <= i_strap_config;
      strap_cfg_q <= strap_cfg_m_q;
      straps_m_q <= i_fixed_port_straps;
      straps_q <= straps_m_q;
    end
  end

  //--------------------------------------------------------------
  // Power source state machine
  //--------------------------------------------------------------
  assign dynamic_en = cfg2_q[`HCB_CFG2_DYNAMIC];
  assign supply_changed = (sense_q != self_q);

  always @* begin
    state_d = state_q;
    settle_d = settle_q;
    self_d = self_q;
    detach_cnt_d = detach_cnt_q;
    case (state_q)
      ST_INIT: begin
        settle_d = settle_q + 2'h1;
        if (settle_q == SETTLE_LAST) begin
          self_d = sense_q;
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (dynamic_en && supply_changed) begin
          self_d = sense_q;
          detach_cnt_d = DETACH_CYC;
          state_d = ST_DETACH;
        end
      end
      ST_DETACH: begin
        if (detach_cnt_q <= DETACH_ONE) begin
          state_d = ST_RUN;
        end else begin
          detach_cnt_d = detach_cnt_q - DETACH_ONE;
        end
      end
      default: begin
        state_d = ST_INIT;
      end
    endcase
  end

  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_q <= ST_INIT;
      settle_q <= 2'h0;
      self_q <= 1'b0;
      detach_cnt_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      settle_q <= settle_d;
      self_q <= self_d;
      detach_cnt_q <= detach_cnt_d;
    end
  end

  assign o_self_powered = self_q;
  assign o_upstream_attach = (state_q == ST_RUN);
  assign o_port_power_en = (state_q == ST_RUN);
  assign o_downstream_disconnect = (state_q != ST_RUN);

  //--------------------------------------------------------------
  // Over-current filter
  //--------------------------------------------------------------
  assign oc_code = cfg2_q[`HCB_CFG2_OC_HI:`HCB_CFG2_OC_LO];

  // Level must hold unbroken for the whole delay; any release restarts
  always @* begin
    oc_expired = (oc_cnt_q + OC_ONE >= oc_limit(oc_code));
    oc_cnt_d = oc_cnt_q;
    oc_flag_d = o_overcurrent;
    if (!oc_q) begin
      oc_cnt_d = 19'h00000;
      oc_flag_d = 1'b0;
    end else if (oc_expired) begin
      oc_flag_d = 1'b1;
    end else begin
      oc_cnt_d = oc_cnt_q + OC_ONE;
    end
  end

  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      oc_cnt_q <= 19'h00000;
      o_overcurrent <= 1'b0;
    end else begin
      oc_cnt_q <= oc_cnt_d;
      o_overcurrent <= oc_flag_d;
    end
  end

  //--------------------------------------------------------------
  // Reported configuration
  //--------------------------------------------------------------
  always @* begin
    strap_mask = strap_decode(straps_q);
  end

  assign ind_code = cfg3_q[`HCB_CFG3_IND_HI:`HCB_CFG3_IND_LO];
  assign o_fixed_port_mask = strap_cfg_q ? strap_mask : mask_q[7:1];
  assign o_compound = strap_cfg_q ? (|strap_mask) : cfg2_q[`HCB_CFG2_COMPOUND];
  assign o_port_renumber_en = cfg3_q[`HCB_CFG3_RENUM];
  assign o_indicator_speed_mode = (ind_code == `HCB_IND_SPEED);
  assign o_indicator_support = ~o_indicator_speed_mode;
  assign o_string_en = cfg3_q[`HCB_CFG3_STRING];

endmodule
`default_nettype wire

// file: hcb_config_bytes_assertions.sv
// Concurrent checks on the hub config slice ports
`timescale 1ns/1ps
`default_nettype none
module hcb_config_bytes_chk (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [7:0] i_cfg_wdata,
  input wire logic [7:0] o_cfg_rdata,
  input wire logic i_strap_config,
  input wire logic [1:0] i_fixed_port_straps,
  input wire logic o_self_powered,
  input wire logic o_upstream_attach,
  input wire logic o_downstream_disconnect,
  input wire logic o_overcurrent,
  input wire logic o_compound,
  input wire logic o_port_renumber_en,
  input wire logic o_indicator_speed_mode,
  input wire logic o_indicator_support,
  input wire logic o_string_en
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  wire w8 = i_cfg_wr && i_cfg_addr == 8'h08;
  wire r_un = i_cfg_rd && (i_cfg_addr < 8'h07 || i_cfg_addr > 8'h09);
  chk_rd_unmapped: assert property (r_un |=> o_cfg_rdata == 8'h00) else $error("unmapped read");
  chk_mask_bit0: assert property (i_cfg_rd && i_cfg_addr == 8'h09 |=> !o_cfg_rdata[0])
    else $error("mask bit0 set");
  chk_cfg2_resv: assert property (i_cfg_rd && i_cfg_addr == 8'h07 |=> (o_cfg_rdata & 8'h47) == 8'h00)
    else $error("byte2 reserved set");
  chk_cfg3_resv: assert property (i_cfg_rd && i_cfg_addr == 8'h08 |=> o_cfg_rdata[7:4] == 4'h0)
    else $error("byte3 reserved set");
  chk_speed_sel: assert property (w8 && i_cfg_wdata[2:1] == 2'h1 |=> o_indicator_speed_mode)
    else $error("speed mode missing");
  chk_support_inv: assert property (o_indicator_support != o_indicator_speed_mode)
    else $error("indicator support wrong");
  chk_renum_set: assert property (w8 && i_cfg_wdata[3] |=> o_port_renumber_en)
    else $error("renumber missing");
  chk_string_clr: assert property (w8 && !i_cfg_wdata[0] |=> !o_string_en)
    else $error("string still on");
  chk_strap_comp: assert property ((i_strap_config && i_fixed_port_straps != 2'h0) [*3] |->
    o_compound)
    else $error("strap compound missing");
  chk_detach_now: assert property ($changed(o_self_powered) && $past(o_upstream_attach) |->
    !o_upstream_attach && o_downstream_disconnect) else $error("no detach on power change");
  cover property (w8);
  cover property ($fell(o_upstream_attach));
  cover property ($rose(o_overcurrent));
endmodule
bind hcb_config_bytes hcb_config_bytes_chk u_chk (.*);
`default_nettype wire

// file: hcb_host_model.sv
// Upstream host model: counts hub attaches and the power mode seen
`timescale 1ns/1ps
`default_nettype none
module hcb_host_model (
  input wire logic i_clock,
  input wire logic i_attach,
  input wire logic i_self_powered,
  output var int o_attaches,
  output var logic o_seen_self
);
  logic prev_q = 1'b0;
  initial o_attaches = 0;
  initial o_seen_self = 1'b0;
  always @(posedge i_clock) begin
    prev_q <= i_attach;
    if (i_attach && !prev_q) begin
      o_attaches <= o_attaches + 1;
      o_seen_self <= i_self_powered;
    end
  end
endmodule
`default_nettype wire

// file: test_hub_config_bytes_power_led_nrd.sv
// Self-checking bench for the hub config slice
`timescale 1ns/1ps
`default_nettype none
module test_hub_config_bytes_power_led_nrd;
  logic i_clock = 0, i_rst_n = 0, wr = 0, rd = 0, strap = 0, sense = 0, oc_n = 1, hself;
  logic self, att, pwr, disc, oc, comp, ren, spd, sup, str;
  logic [7:0] addr = 0, wd = 0, rdata, ra, rv;
  logic [7:1] fmask;
  logic [1:0] straps = 0;
  logic [31:0] seed = 32'he80c;
  int miscompares = 0, checks = 0, n, hosts;
  always #25 i_clock = ~i_clock;
  hcb_config_bytes #(.OC_CYC0(19'd4), .OC_CYC1(19'd8), .OC_CYC2(19'd12), .OC_CYC3(19'd16),
    .DETACH_CYC(16'd5)) u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_cfg_wr(wr),
    .i_cfg_rd(rd), .i_cfg_addr(addr), .i_cfg_wdata(wd), .o_cfg_rdata(rdata),
    .i_strap_config(strap), .i_fixed_port_straps(straps), .i_local_supply_sense(sense),
    .i_overcurrent_n(oc_n), .o_self_powered(self), .o_upstream_attach(att),
    .o_port_power_en(pwr), .o_downstream_disconnect(disc), .o_overcurrent(oc),
    .o_compound(comp), .o_fixed_port_mask(fmask), .o_port_renumber_en(ren),
    .o_indicator_speed_mode(spd), .o_indicator_support(sup), .o_string_en(str));
  hcb_host_model u_host (.i_clock(i_clock), .i_attach(att), .i_self_powered(self),
    .o_attaches(hosts), .o_seen_self(hself));
  function logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function logic [7:0] wm(input logic [7:0] a);
    return a == 8'h07 ? 8'hB8 : a == 8'h08 ? 8'h0F : a == 8'h09 ? 8'hFE : 8'h00;
  endfunction
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clock);
    #5;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    wr = 1;
    cyc(1);
    wr = 0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    rd = 1;
    cyc(1);
    rd = 0;
    cmp("rdata", e, rdata);
  endtask
  task automatic wait_att(input logic v);
    n = 0;
    while (att !== v && n < 100) begin
      cyc(1);
      n++;
    end
    cmp("attach", {5'h0, v, v, !v}, {5'h0, att, pwr, disc});
  endtask
  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #(3000 * 50);
    miscompares++;
    conclude;
  end
  initial begin
    cyc(4);
    i_rst_n = 1;
    cyc(6);
    for (int a = 7; a < 11; a++) rd_reg(a[7:0], 8'h00);
    for (int a = 7; a < 10; a++) begin
      wr_reg(a[7:0], 8'hFF);
      rd_reg(a[7:0], wm(a[7:0]));
    end
    $display("test reset and reserved done");
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      ra = seed[9:8] == 2'h3 ? 8'h0A : 8'h07 + {6'h0, seed[9:8]};
      rv = seed[7:0];
      if (i < 4) ra = 8'h08;
      if (i < 4) rv = {rv[7:3], i[1:0], rv[0]};
      wr_reg(ra, rv);
      rd_reg(ra, rv & wm(ra));
      if (ra == 8'h08) cmp("led", {4'h0, rv[3], rv[2:1] == 2'h1, rv[2:1] != 2'h1, rv[0]},
        {4'h0, ren, spd, sup, str});
      if (ra == 8'h09) cmp("fixed", {rv[7:1], 1'b0}, {fmask, 1'b0});
      if (ra == 8'h07) cmp("compound", {7'h0, rv[3]}, {7'h0, comp});
    end
    $display("test random access done");
    wr_reg(8'h07, 8'h00);
    strap = 1;
    for (int s = 0; s < 4; s++) begin
      straps = s[1:0];
      cyc(3);
      cmp("strap", {7'((1 << s) - 1), s != 0}, {fmask, comp});
    end
    strap = 0;
    $display("test straps done");
    sense = 1;
    cyc(10);
    cmp("static", 8'h02, {6'h0, att, self});
    sense = 0;
    cyc(4);
    wr_reg(8'h07, 8'h80);
    for (int k = 0; k < 2; k++) begin
      sense = ~sense;
      wait_att(1'b0);
      cmp("self", {7'h0, sense}, {7'h0, self});
      wait_att(1'b1);
      cyc(1);
      cmp("host", {6'h0, sense, 1'b1}, {6'h0, hself, hosts == 2 + k});
    end
    $display("test power switching done");
    for (int c = 0; c < 4; c++) begin
      wr_reg(8'h07, {2'h0, c[1:0], 4'h0});
      oc_n = 0;
      n = 0;
      while (oc !== 1'b1 && n < 60) begin
        cyc(1);
        n++;
      end
      cmp("oc_delay", 8'h01, 8'(n >= 4 * (c + 1) && n <= 4 * (c + 1) + 4));
      oc_n = 1;
      cyc(4);
      cmp("oc_clear", 8'h00, {7'h0, oc});
    end
    $display("test over-current done");
    conclude;
  end
endmodule
`default_nettype wire
